/* verilog/aclm_pkg.sv */
// Purpose: constants and carriers for one layer-4 / ethertype match entry
// Assumes: ahb-lite register access, one word per register, 125 MHz clk
// Notes: Contract list below; register offsets are byte addresses
//
// Contract
// - source port: any, exact or range; any ignores
// - exact source port must equal 16-bit value
// - range source port must lie within bounds
// - destination port: independent any, exact, range
// - exact destination port must equal value
// - range destination port must lie within bounds
// - fin criterion: zero, one or any
// - syn criterion: zero, one or any
// - rst criterion: zero, one or any
// - psh criterion: zero, one or any
// - ack criterion: zero, one or any
// - urg criterion: zero, one or any
// - ethertype checked only in ethertype class
// - ethertype filter: any or exact compare
// - exact ethertype 0x600..0xffff, equal frames hit; the code also refuses 0x800, 0x806 and 0x86dd
// - ports/flags only for tcp/udp; flags tcp only
package aclm_pkg;

  // widths
  localparam int PORT_W = 16;
  localparam int ETYPE_W = 16;
  localparam int NFLAGS = 6;

  // register byte offsets
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_SPORT = 32'h0000_0004;
  localparam logic [31:0] OFF_DPORT = 32'h0000_0008;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_000c;
  localparam logic [31:0] OFF_ETYPE = 32'h0000_0010;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0014;
  localparam logic [31:0] OFF_LIMIT = 32'h0000_0018;

  // ctrl field positions
  localparam int CTRL_CLASS_BIT = 0;
  localparam int CTRL_L4_LSB = 1;
  localparam int CTRL_SP_LSB = 3;
  localparam int CTRL_DP_LSB = 5;
  localparam int CTRL_ET_BIT = 7;
  localparam int CTRL_EN_BIT = 8;

  // port register halves, status fields
  localparam int PORT_LO_LSB = 0;
  localparam int PORT_HI_LSB = 16;
  localparam int ST_HIT_BIT = 0;
  localparam int ST_REJ_BIT = 1;
  localparam int ST_CNT_LSB = 16;

  // port filter modes (3 reads as any)
  localparam logic [1:0] PM_ANY = 2'h0;
  localparam logic [1:0] PM_EXACT = 2'h1;
  localparam logic [1:0] PM_RANGE = 2'h2;

  // layer-4 protocol selector
  localparam logic [1:0] L4_NONE = 2'h0;
  localparam logic [1:0] L4_TCP = 2'h1;
  localparam logic [1:0] L4_UDP = 2'h2;

  // tcp flag criterion codes (2 and 3 read as any)
  localparam logic [1:0] FL_ZERO = 2'h0;
  localparam logic [1:0] FL_ONE = 2'h1;

  // ethertype limits and refused codes
  localparam logic [15:0] ETYPE_MIN = 16'h0600;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [15:0] ETYPE_ARP = 16'h0806;
  localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;

  // values after reset
  localparam logic [11:0] FLAGS_RST = 12'hfff;
  localparam logic [15:0] ETYPE_RST = 16'h0600;
  localparam logic [15:0] PORT_HI_RST = 16'hffff;

  // parsed header from the receive path, one-cycle valid
  typedef struct packed {
    logic valid;
    logic is_ip;
    logic is_arp;
    logic is_tcp;
    logic is_udp;
    logic [ETYPE_W-1:0] etype;
    logic [PORT_W-1:0] sport;
    logic [PORT_W-1:0] dport;
    logic [NFLAGS-1:0] tcp_flags; // fin,syn,rst,psh,ack,urg from bit 0
  } aclm_hdr_t;

  // verdict, one cycle after the header
  typedef struct packed {
    logic valid;
    logic hit;
  } aclm_res_t;

  // legal exact ethertype value
  function automatic logic et_legal(input logic [15:0] v);
    et_legal = (v >= ETYPE_MIN) && (v != ETYPE_IPV4) &&
               (v != ETYPE_ARP) && (v != ETYPE_IPV6);
  endfunction

endpackage

/* verilog/aclm_port_filter.sv */
// Purpose: one layer-4 port criterion: any, exact value or range
// Assumes: mode codes from aclm_pkg, combinational use
// Notes: range bounds are inclusive
`timescale 1ns/100ps
module aclm_port_filter #(
  parameter int W = 16
) (
  // criterion configuration
  input wire logic [1:0] mode,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  // frame port and verdict
  input wire logic [W-1:0] port,
  output logic ok
);

  // refuse widths the compare cannot serve
  generate
    if (W < 1 || W > 32) begin : g_bad_width
      $error("aclm_port_filter: W must be 1 to 32");
    end
  endgenerate

  // mode select of the compare
  always_comb begin
    case (mode)
      aclm_pkg::PM_EXACT: ok = (port == lo);
      aclm_pkg::PM_RANGE: ok = (port >= lo) && (port <= hi);
      default: ok = 1'b1;
    endcase
  end

endmodule

/* verilog/aclm_match_entry.sv */
// Purpose: one access-control match entry over layer-4 and ethertype
// Assumes: headers come from logic on clk; ahb-lite single word access
// Notes: verdict one cycle after the header; zero-wait bus slave
`timescale 1ns/100ps
module aclm_match_entry (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // parsed frame headers and verdict
  input wire aclm_pkg::aclm_hdr_t hdr,
  output aclm_pkg::aclm_res_t result
);

  // whole state of the entry
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic ap_hit;
    logic [31:0] ap_addr;
    logic [31:0] rdata;
    logic cls_etype;
    logic [1:0] l4_sel;
    logic [1:0] sp_mode;
    logic [1:0] dp_mode;
    logic et_exact;
    logic enable;
    logic [15:0] sp_lo;
    logic [15:0] sp_hi;
    logic [15:0] dp_lo;
    logic [15:0] dp_hi;
    logic [15:0] et_val;
    logic [11:0] flag_cfg;
    logic et_rej;
    logic res_valid;
    logic res_hit;
    logic last_hit;
    logic [15:0] hit_cnt;
  } aclm_state_t;

  localparam aclm_state_t ST_RST = '{
    sp_hi: aclm_pkg::PORT_HI_RST,
    dp_hi: aclm_pkg::PORT_HI_RST,
    et_val: aclm_pkg::ETYPE_RST,
    flag_cfg: aclm_pkg::FLAGS_RST,
    default: '0
  };

  aclm_state_t q_q;
  aclm_state_t q_d;
  logic sp_ok;
  logic dp_ok;
  logic fl_ok;
  logic et_ok;
  logic l4_ok;
  logic all_ok;
  logic ap_take;
  logic mapped;

  // one three-state tcp flag criterion
  function automatic logic flag_ok(input logic [1:0] cfg, input logic f);
    case (cfg)
      aclm_pkg::FL_ZERO: flag_ok = !f;
      aclm_pkg::FL_ONE: flag_ok = f;
      default: flag_ok = 1'b1;
    endcase
  endfunction

  // source and destination port criteria
  aclm_port_filter #(.W(aclm_pkg::PORT_W)) u_src (
    .mode(q_q.sp_mode),
    .lo(q_q.sp_lo),
    .hi(q_q.sp_hi),
    .port(hdr.sport),
    .ok(sp_ok)
  );

  aclm_port_filter #(.W(aclm_pkg::PORT_W)) u_dst (
    .mode(q_q.dp_mode),
    .lo(q_q.dp_lo),
    .hi(q_q.dp_hi),
    .port(hdr.dport),
    .ok(dp_ok)
  );

  // flag, ethertype and protocol terms, anded into the verdict
  always_comb begin
    fl_ok = 1'b1;
    for (int i = 0; i < aclm_pkg::NFLAGS; i++) begin
      fl_ok = fl_ok && flag_ok(q_q.flag_cfg[2*i +: 2],
                               hdr.tcp_flags[i]);
    end
    et_ok = !q_q.et_exact || (hdr.etype == q_q.et_val);
    case (q_q.l4_sel)
      aclm_pkg::L4_TCP: l4_ok = hdr.is_tcp && sp_ok && dp_ok && fl_ok;
      aclm_pkg::L4_UDP: l4_ok = hdr.is_udp && sp_ok && dp_ok;
      default: l4_ok = 1'b1;
    endcase
    if (q_q.cls_etype) begin
      all_ok = q_q.enable && !hdr.is_ip && !hdr.is_arp && et_ok;
    end else begin
      all_ok = q_q.enable && hdr.is_ip && l4_ok;
    end
  end

  // address phase decode
  assign ap_take = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0) &&
                  (haddr[4:2] <= aclm_pkg::OFF_LIMIT[4:2]) &&
                  (haddr != aclm_pkg::OFF_LIMIT);

  // next state: bus, configuration, verdict and status
  always_comb begin
    q_d = q_q;
    q_d.ap_valid = ap_take;
    q_d.ap_write = hwrite;
    q_d.ap_hit = mapped;
    q_d.ap_addr = haddr;
    q_d.rdata = 32'h0;
    if (ap_take && !hwrite && mapped) begin
      case (haddr)
        aclm_pkg::OFF_CTRL: begin
          q_d.rdata[aclm_pkg::CTRL_CLASS_BIT] = q_q.cls_etype;
          q_d.rdata[aclm_pkg::CTRL_L4_LSB +: 2] = q_q.l4_sel;
          q_d.rdata[aclm_pkg::CTRL_SP_LSB +: 2] = q_q.sp_mode;
          q_d.rdata[aclm_pkg::CTRL_DP_LSB +: 2] = q_q.dp_mode;
          q_d.rdata[aclm_pkg::CTRL_ET_BIT] = q_q.et_exact;
          q_d.rdata[aclm_pkg::CTRL_EN_BIT] = q_q.enable;
        end
        aclm_pkg::OFF_SPORT: q_d.rdata = {q_q.sp_hi, q_q.sp_lo};
        aclm_pkg::OFF_DPORT: q_d.rdata = {q_q.dp_hi, q_q.dp_lo};
        aclm_pkg::OFF_FLAGS: q_d.rdata = {20'h0, q_q.flag_cfg};
        aclm_pkg::OFF_ETYPE: q_d.rdata = {16'h0, q_q.et_val};
        aclm_pkg::OFF_STATUS: begin
          q_d.rdata[aclm_pkg::ST_HIT_BIT] = q_q.last_hit;
          q_d.rdata[aclm_pkg::ST_REJ_BIT] = q_q.et_rej;
          q_d.rdata[aclm_pkg::ST_CNT_LSB +: 16] = q_q.hit_cnt;
        end
        default: q_d.rdata = 32'h0;
      endcase
    end
    // data phase of a write lands here
    if (q_q.ap_valid && q_q.ap_write && q_q.ap_hit) begin
      case (q_q.ap_addr)
        aclm_pkg::OFF_CTRL: begin
          q_d.cls_etype = hwdata[aclm_pkg::CTRL_CLASS_BIT];
          q_d.l4_sel = hwdata[aclm_pkg::CTRL_L4_LSB +: 2];
          q_d.sp_mode = hwdata[aclm_pkg::CTRL_SP_LSB +: 2];
          q_d.dp_mode = hwdata[aclm_pkg::CTRL_DP_LSB +: 2];
          q_d.et_exact = hwdata[aclm_pkg::CTRL_ET_BIT];
          q_d.enable = hwdata[aclm_pkg::CTRL_EN_BIT];
        end
        aclm_pkg::OFF_SPORT: begin
          q_d.sp_lo = hwdata[aclm_pkg::PORT_LO_LSB +: 16];
          q_d.sp_hi = hwdata[aclm_pkg::PORT_HI_LSB +: 16];
        end
        aclm_pkg::OFF_DPORT: begin
          q_d.dp_lo = hwdata[aclm_pkg::PORT_LO_LSB +: 16];
          q_d.dp_hi = hwdata[aclm_pkg::PORT_HI_LSB +: 16];
        end
        aclm_pkg::OFF_FLAGS: q_d.flag_cfg = hwdata[11:0];
        aclm_pkg::OFF_ETYPE: begin
          // refused codes keep the old value and raise the flag
          if (aclm_pkg::et_legal(hwdata[15:0])) begin
            q_d.et_val = hwdata[15:0];
            q_d.et_rej = 1'b0;
          end else begin
            q_d.et_rej = 1'b1;
          end
        end
        aclm_pkg::OFF_STATUS: q_d.hit_cnt = 16'h0; // any write clears
        default: q_d.et_rej = q_q.et_rej; // unmapped: nothing changes
      endcase
    end
    // verdict; a hit in the clearing cycle still counts
    q_d.res_valid = hdr.valid;
    q_d.res_hit = hdr.valid && all_ok;
    if (hdr.valid) begin
      q_d.last_hit = all_ok;
      if (all_ok) begin
        q_d.hit_cnt = q_d.hit_cnt + 16'h1;
      end
    end
  end

  // the one state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= ST_RST;
    end else begin
      q_q <= q_d;
    end
  end

  // outputs
  assign hrdata = q_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign result = '{valid: q_q.res_valid, hit: q_q.res_hit};

  // checks on the verdict and the ethertype register
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ip_entry;
    hdr.valid && q_q.enable && !q_q.cls_etype && hdr.is_ip;
  endsequence

  sequence s_tcp_frame;
    s_ip_entry ##0 (q_q.l4_sel == aclm_pkg::L4_TCP) && hdr.is_tcp;
  endsequence

  sequence s_et_write;
    q_q.ap_valid && q_q.ap_write && q_q.ap_hit &&
    (q_q.ap_addr == aclm_pkg::OFF_ETYPE);
  endsequence

  property p_flag(int i);
    (hdr.valid && !q_q.cls_etype && q_q.l4_sel == aclm_pkg::L4_TCP &&
     ((q_q.flag_cfg[2*i +: 2] == aclm_pkg::FL_ZERO && hdr.tcp_flags[i]) ||
      (q_q.flag_cfg[2*i +: 2] == aclm_pkg::FL_ONE && !hdr.tcp_flags[i])))
    |=> !result.hit;
  endproperty

  a_src_any_hit: assert property (
    s_tcp_frame ##0 (q_q.sp_mode == aclm_pkg::PM_ANY) && dp_ok && fl_ok
    |=> result.valid && result.hit)
    else $error("any source port mode blocked a hit");
  a_src_exact_miss: assert property (
    hdr.valid && q_q.l4_sel != aclm_pkg::L4_NONE && !q_q.cls_etype &&
    q_q.sp_mode == aclm_pkg::PM_EXACT && hdr.sport != q_q.sp_lo
    |=> !result.hit)
    else $error("unequal source port hit");
  a_src_range_miss: assert property (
    hdr.valid && q_q.l4_sel != aclm_pkg::L4_NONE && !q_q.cls_etype &&
    q_q.sp_mode == aclm_pkg::PM_RANGE &&
    (hdr.sport < q_q.sp_lo || hdr.sport > q_q.sp_hi)
    |=> !result.hit)
    else $error("source port outside range hit");
  a_src_range_edge: assert property (
    s_tcp_frame ##0 q_q.sp_mode == aclm_pkg::PM_RANGE &&
    hdr.sport == q_q.sp_hi && q_q.sp_lo <= q_q.sp_hi && dp_ok && fl_ok
    |=> result.hit)
    else $error("upper range bound not inclusive");
  a_dst_any_hit: assert property (
    s_tcp_frame ##0 (q_q.dp_mode == aclm_pkg::PM_ANY) && sp_ok && fl_ok
    |=> result.hit)
    else $error("any destination port mode blocked a hit");
  a_dst_exact_miss: assert property (
    hdr.valid && q_q.l4_sel != aclm_pkg::L4_NONE && !q_q.cls_etype &&
    q_q.dp_mode == aclm_pkg::PM_EXACT && hdr.dport != q_q.dp_lo
    |=> !result.hit)
    else $error("unequal destination port hit");
  a_dst_range_low: assert property (
    s_tcp_frame ##0 q_q.dp_mode == aclm_pkg::PM_RANGE &&
    hdr.dport == q_q.dp_lo && q_q.dp_lo <= q_q.dp_hi && sp_ok && fl_ok
    |=> result.hit)
    else $error("lower destination bound not inclusive");
  a_flag_fin: assert property (p_flag(0))
    else $error("fin criterion ignored");
  a_flag_syn: assert property (p_flag(1))
    else $error("syn criterion ignored");
  a_flag_rst: assert property (p_flag(2))
    else $error("rst criterion ignored");
  a_flag_psh: assert property (p_flag(3))
    else $error("psh criterion ignored");
  a_flag_ack: assert property (p_flag(4))
    else $error("ack criterion ignored");
  a_flag_urg: assert property (p_flag(5))
    else $error("urg criterion ignored");
  a_et_class_only: assert property (
    hdr.valid && q_q.cls_etype && (hdr.is_ip || hdr.is_arp)
    |=> !result.hit)
    else $error("ip frame hit an ethertype entry");
  a_et_any_hit: assert property (
    hdr.valid && q_q.enable && q_q.cls_etype && !q_q.et_exact &&
    !hdr.is_ip && !hdr.is_arp
    |=> result.hit)
    else $error("any ethertype mode blocked a hit");
  a_et_exact_miss: assert property (
    hdr.valid && q_q.cls_etype && q_q.et_exact &&
    hdr.etype != q_q.et_val
    |=> !result.hit)
    else $error("unequal ethertype hit");
  a_et_refused: assert property (
    s_et_write ##0 !aclm_pkg::et_legal(hwdata[15:0])
    |=> q_q.et_val == $past(q_q.et_val) && q_q.et_rej)
    else $error("refused ethertype was stored");
  a_udp_needs_udp: assert property (
    hdr.valid && !q_q.cls_etype && q_q.l4_sel == aclm_pkg::L4_UDP &&
    !hdr.is_udp
    |=> !result.hit)
    else $error("non-udp frame hit a udp entry");
  a_hit_and: assert property (
    hdr.valid |=> result.valid && result.hit == $past(all_ok))
    else $error("verdict does not follow the criteria");

endmodule

/* tb/aclm_rx_model.sv */
// Purpose: receive-path model handing parsed headers to the match entry
// Assumes: same clk as the entry; fields change just after rising edges
// Notes: idle cycles alternate inverted and unchanged fields of the last frame, valid low
`timescale 1ns/100ps
module aclm_rx_model (
  // clock
  input wire logic clk,
  // parsed header towards the entry
  output aclm_pkg::aclm_hdr_t hdr
);
  initial hdr = '0;

  // one header for one cycle, then gap idle cycles of alternately inverted fields
  task automatic send(input aclm_pkg::aclm_hdr_t h, input int gap);
    h.valid = 1'b1;
    hdr <= h;
    @(posedge clk);
    for (int i = 0; i < gap; i++) begin
      h = ~h;
      h.valid = 1'b0;
      hdr <= h;
      @(posedge clk);
    end
  endtask
endmodule

/* tb/aclm_match_entry_tb.sv */
// Purpose: self-checking bench for one layer-4 / ethertype match entry
// Assumes: zero-wait ahb-lite slave, verdict one cycle after the header
// Notes: verdicts compared with an integer model at every result
`timescale 1ns/100ps
module aclm_match_entry_tb;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r, lo, hi, v;
  aclm_pkg::aclm_hdr_t hdr, h;
  aclm_pkg::aclm_res_t result;
  int failures, total_checks, hit_cnt;
  logic [31:0] c_ctrl, c_sp, c_dp, c_fl, c_et;
  logic pend, exp_hit, last_v, rej;
  logic exp_q [$];
  logic [31:0] offs [7];
  logic [31:0] rstv [7];
  logic [15:0] bad [5];

  aclm_match_entry aclm_match_entry_i (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hdr(hdr), .result(result));
  aclm_rx_model aclm_rx_model_i (.clk(clk), .hdr(hdr));

  // free-running clock, 8 ns
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one single-word transfer; read data taken at the edge ending data phase
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp", hresp, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rc(input string n, input logic [31:0] a, m, e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(n, q & m, e);
  endtask

  function automatic logic okty(input logic [15:0] t);
    return t >= 16'h0600 && t != 16'h0800 && t != 16'h0806 &&
           t != 16'h86dd;
  endfunction

  function automatic logic pf(input logic [1:0] m, input logic [31:0] c,
                              input logic [15:0] p);
    if (m == 2'h1) return p == c[15:0];
    if (m == 2'h2) return p >= c[15:0] && p <= c[31:16];
    return 1'b1;
  endfunction

  function automatic logic model(input aclm_pkg::aclm_hdr_t x);
    logic fl, l4;
    fl = 1'b1;
    for (int i = 0; i < 6; i++)
      if (!c_fl[2*i+1] && c_fl[2*i] != x.tcp_flags[i]) fl = 1'b0;
    l4 = pf(c_ctrl[4:3], c_sp, x.sport) && pf(c_ctrl[6:5], c_dp, x.dport);
    case (c_ctrl[2:1])
      2'h1: l4 = l4 && x.is_tcp && fl;
      2'h2: l4 = l4 && x.is_udp;
      default: l4 = 1'b1;
    endcase
    if (c_ctrl[0])
      return c_ctrl[8] && !x.is_ip && !x.is_arp &&
             (!c_ctrl[7] || x.etype == c_et[15:0]);
    return c_ctrl[8] && x.is_ip && l4;
  endfunction

  function automatic logic [15:0] pk(input logic [31:0] c);
    case ($urandom % 5)
      0: return c[15:0];
      1: return c[31:16];
      2: return c[15:0] - 16'h1;
      3: return c[31:16] + 16'h1;
      default: return 16'($urandom);
    endcase
  endfunction

  // verdict one cycle after each header, low otherwise
  always @(negedge clk) begin
    pend = exp_q.size() != 0;
    if (pend) exp_hit = exp_q.pop_front();
    check("result.valid", result.valid, pend);
    check("result.hit", result.hit, pend & exp_hit);
    if (pend) last_v = exp_hit;
    if (pend && exp_hit) hit_cnt++;
    if (hdr.valid) exp_q.push_back(model(hdr));
  end

  // watchdog against a hung bus or frame path
  initial begin
    #400000;
    failures++;
    report_and_stop;
  end

  // main sequence
  initial begin
    void'($urandom(32'hc29c376d));
    offs = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14, 32'h18};
    rstv = '{32'h0, 32'hffff0000, 32'hffff0000, 32'hfff, 32'h600, 0, 0};
    bad = '{16'h0800, 16'h0806, 16'h86dd, 16'h05ff, 16'h0600};
    {c_ctrl, c_sp, c_dp, c_fl, c_et} = {32'h0, rstv[1], rstv[2],
                                        rstv[3], rstv[4]};
    {pend, exp_hit, last_v, hit_cnt} = '0;
    {rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rc("reset value", offs[i], 32'hffffffff, rstv[i]);
    wr(32'h20, 32'hffffffff);
    rc("unmapped", 32'h20, 32'hffffffff, 32'h0);
    // refused and accepted exact ethertype codes
    for (int i = 0; i < 5; i++) begin
      rej = !okty(bad[i]);
      if (!rej) c_et = {16'h0, bad[i]};
      wr(32'h10, {16'h0, bad[i]});
      rc("etype", 32'h10, 32'hffff, c_et);
      rc("refused", 32'h14, 32'h2, {30'h0, rej, 1'b0});
    end
    // random entry settings, each followed by a burst of frames
    for (int k = 0; k < 30; k++) begin
      c_ctrl = {23'h0, $urandom % 4 != 0, 1'($urandom), 4'($urandom),
                2'($urandom % 3), 1'($urandom)};
      lo = (k % 4 == 0) ? 32'h0 : $urandom % 65528;
      hi = (k % 4 == 0) ? 32'hffff : lo + $urandom % 8;
      c_sp = {hi[15:0], lo[15:0]};
      c_dp = {hi[15:0] ^ 16'h0, lo[15:0]};
      c_fl = $urandom % 4096;
      do v = $urandom % 65536; while (!okty(v[15:0]));
      c_et = v;
      wr(32'h0, c_ctrl);
      wr(32'h4, c_sp);
      wr(32'h8, c_dp);
      wr(32'hc, c_fl);
      wr(32'h10, c_et);
      wr(32'h14, 32'h0);
      hit_cnt = 0;
      for (int j = 0; j < 12; j++) begin
        h = '0;
        h.is_ip = ($urandom % 4 != 0) ^ c_ctrl[0];
        h.is_arp = ($urandom % 6 == 0);
        h.is_tcp = c_ctrl[2:1] == 2'h1 ? $urandom % 5 != 0 : $urandom;
        h.is_udp = c_ctrl[2:1] == 2'h2 ? $urandom % 5 != 0 : $urandom;
        h.sport = pk(c_sp);
        h.dport = pk(c_dp);
        h.etype = $urandom % 2 ? c_et[15:0] : 16'($urandom);
        for (int i = 0; i < 6; i++)
          h.tcp_flags[i] = ($urandom % 8 == 0) ? ~c_fl[2*i] :
                           (c_fl[2*i+1] ? 1'($urandom) : c_fl[2*i]);
        aclm_rx_model_i.send(h, j == 11 ? 2 : $urandom % 3);
      end
      rc("hit count", 32'h14, 32'hffff0000, hit_cnt << 16);
      rc("last verdict", 32'h14, 32'h1, {31'h0, last_v});
    end
    report_and_stop;
  end
endmodule
